// ### design/svw_supervisor.sv
// top of the supervisor: channel faults, shared reset and watchdog
// Overview of operation
// R1 - kick input constant beyond timeout asserts reset and clears the timer
// R2 - timer clears on any reset and on each kick edge
// R3 - after reset the first kick edge may take up to 54 s
// R4 - a floating kick input disables the watchdog; host leaves it undriven
// R5 - each channel fault output is low while its supply is below threshold
// R6 - reset asserts on low channel or manual reset, held timeout after release
// R7 - timeout select high uses internal reset hold of at least 140 ms
// R8 - test override low forces all fault and reset outputs high
// R9 - watchdog timeout is 1.6 s from the latest kick edge
`timescale 1ns/100ps
`default_nettype none
module svw_supervisor #(
    parameter logic [31:0] STARTUP_CYC  = 32'(svw_pkg::WD_STARTUP_CYC),
    parameter logic [31:0] TIMEOUT_CYC  = 32'(svw_pkg::WD_TIMEOUT_CYC),
    parameter logic [31:0] RST_HOLD_CYC = 32'(svw_pkg::RST_HOLD_CYC)
) (
    input  wire logic   clk_sys,
    input  wire logic   arst_n,
    input  wire logic   monitored_supply_5,
    input  wire logic   monitored_supply_6,
    input  wire logic   monitored_supply_7,
    input  wire logic   monitored_supply_8,
    input  wire logic   watchdog_kick_input,
    input  wire logic   watchdog_kick_floating,
    input  wire logic   manual_reset_input_n,
    input  wire logic   timeout_select_pin,
    input  wire logic   ext_timeout_done,
    input  wire logic   margin_n,
    output logic        channel_fault_5_n,
    output logic        channel_fault_6_n,
    output logic        channel_fault_7_n,
    output logic        channel_fault_8_n,
    output logic        reset_out_n,
    output logic        ext_timeout_run
);
    logic [1:0]                         rst_sync;
    logic                               rst_n;
    logic [svw_pkg::NUM_CH-1:0]         below;
    logic [svw_pkg::NUM_CH-1:0]         fault_n;
    logic                               cause;
    logic                               holding;
    logic [svw_pkg::RST_CNT_W-1:0]      hold_cnt;
    logic                               hold_done;
    svw_wd_if                           wd_bus ();

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= svw_pkg::RST_SYNC_INIT;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // inputs are high when the supply sits below threshold
    assign below = {monitored_supply_8, monitored_supply_7, monitored_supply_6, monitored_supply_5};

    genvar gi;
    generate
        for (gi = 0; gi < svw_pkg::NUM_CH; gi++) begin : g_ch
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    fault_n[gi] <= 1'b1;
                end else begin
                    fault_n[gi] <= !(below[gi] && margin_n); // [R5] [R8]
                end
            end
        end
    endgenerate
    assign channel_fault_5_n = fault_n[0];
    assign channel_fault_6_n = fault_n[1];
    assign channel_fault_7_n = fault_n[2];
    assign channel_fault_8_n = fault_n[3];

    assign cause = (|below) || !manual_reset_input_n || wd_bus.expired; // [R6] [R1]
    assign hold_done = timeout_select_pin ? (hold_cnt >= RST_HOLD_CYC - 32'h1)
                                          : ext_timeout_done; // [R7]

    // reset hold: restarts on every cause, releases after the hold time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            holding         <= 1'b1;
            hold_cnt        <= '0;
            ext_timeout_run <= 1'b0;
        end else if (cause) begin
            holding         <= 1'b1; // [R6]
            hold_cnt        <= '0;
            ext_timeout_run <= 1'b0;
        end else if (holding) begin
            ext_timeout_run <= !timeout_select_pin;
            if (hold_done) begin
                holding         <= 1'b0;
                ext_timeout_run <= 1'b0;
            end else begin
                hold_cnt <= hold_cnt + 32'h1; // [R7]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reset_out_n <= 1'b1;
        end else begin
            reset_out_n <= !(holding && margin_n); // [R8]
        end
    end

    assign wd_bus.enable    = !watchdog_kick_floating; // [R4]
    assign wd_bus.kick      = watchdog_kick_input;
    assign wd_bus.sys_reset = holding; // [R2]

    svw_watchdog #(
        .STARTUP_CYC (STARTUP_CYC),
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_wd (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wd      (wd_bus.wd)
    );
endmodule
`default_nettype wire

// ### design/svw_pkg.sv
// package of constants for the supervisor watchdog and channel block
package svw_pkg;
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned NUM_CH          = 4;
    // watchdog timeout after the first edge, in milliseconds
    localparam int unsigned WD_TIMEOUT_MS   = 1600;
    localparam longint unsigned WD_TIMEOUT_CYC = longint'(WD_TIMEOUT_MS) * CLK_HZ / 1000;
    // startup window after a reset, in seconds
    localparam int unsigned WD_STARTUP_S    = 54;
    localparam longint unsigned WD_STARTUP_CYC = longint'(WD_STARTUP_S) * CLK_HZ;
    // least reset hold time, in milliseconds, rounded up to cycles
    localparam int unsigned RST_HOLD_MS     = 140;
    localparam longint unsigned RST_HOLD_CYC = (longint'(RST_HOLD_MS) * CLK_HZ + 999) / 1000;
    localparam int unsigned WD_CNT_W        = 32;
    localparam int unsigned RST_CNT_W       = 32;
    localparam logic [1:0] RST_SYNC_INIT    = 2'h0;
    typedef enum logic [1:0] {
        SVW_WD_OFF     = 2'b00,
        SVW_WD_STARTUP = 2'b01,
        SVW_WD_RUN     = 2'b10
    } svw_wd_state_t;
endpackage

// ### design/svw_wd_if.sv
// interface carrying watchdog controls and status between modules
`timescale 1ns/100ps
`default_nettype none
interface svw_wd_if;
    logic enable;
    logic kick;
    logic sys_reset;
    logic expired;
    modport ctl (output enable, output kick, output sys_reset, input expired);
    modport wd  (input enable, input kick, input sys_reset, output expired);
endinterface
`default_nettype wire

// ### design/svw_watchdog.sv
// watchdog timer with startup window and edge-cleared counter
`timescale 1ns/100ps
`default_nettype none
module svw_watchdog #(
    parameter logic [31:0] STARTUP_CYC = 32'(svw_pkg::WD_STARTUP_CYC),
    parameter logic [31:0] TIMEOUT_CYC = 32'(svw_pkg::WD_TIMEOUT_CYC)
) (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    svw_wd_if.wd        wd
);
    svw_pkg::svw_wd_state_t                 state;
    logic [svw_pkg::WD_CNT_W-1:0]           count;
    logic                                   kick_d;
    logic                                   edge_seen;
    logic [svw_pkg::WD_CNT_W-1:0]           limit;

    assign edge_seen = wd.kick ^ kick_d;
    assign limit = (state == svw_pkg::SVW_WD_STARTUP) ? STARTUP_CYC : TIMEOUT_CYC;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            kick_d <= 1'b0;
        end else begin
            kick_d <= wd.kick;
        end
    end

    // timer clears on reset, on either kick edge, and on expiry
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= svw_pkg::SVW_WD_STARTUP;
            count      <= '0;
            wd.expired <= 1'b0;
        end else begin
            wd.expired <= 1'b0;
            if (!wd.enable) begin
                state <= svw_pkg::SVW_WD_OFF; // [R4]
                count <= '0;
            end else if (wd.sys_reset) begin
                state <= svw_pkg::SVW_WD_STARTUP; // [R2] [R3]
                count <= '0;
            end else begin
                case (state)
                    svw_pkg::SVW_WD_OFF: begin
                        state <= svw_pkg::SVW_WD_STARTUP;
                        count <= '0;
                    end
                    svw_pkg::SVW_WD_STARTUP, svw_pkg::SVW_WD_RUN: begin
                        if (edge_seen) begin
                            state <= svw_pkg::SVW_WD_RUN; // [R3] [R9]
                            count <= '0; // [R2]
                        end else if (count >= limit - 32'h1) begin
                            wd.expired <= 1'b1; // [R1]
                            count      <= '0;
                        end else begin
                            count <= count + 32'h1;
                        end
                    end
                    default: begin
                        state <= svw_pkg::SVW_WD_STARTUP;
                        count <= '0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/svw_supervisor_properties.sv
// port checker for the supervisor block
`timescale 1ns/100ps
`default_nettype none
module svw_supervisor_properties (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic monitored_supply_5,
    input wire logic monitored_supply_6,
    input wire logic monitored_supply_8,
    input wire logic manual_reset_input_n,
    input wire logic margin_n,
    input wire logic channel_fault_5_n,
    input wire logic channel_fault_8_n,
    input wire logic reset_out_n
);
    logic [1:0] up;
    // skip the edges while the reset synchroniser drains
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n || up != 2'h3);
    chk_faults_independent: assert property (margin_n && monitored_supply_5 && !monitored_supply_8
        |=> !channel_fault_5_n && channel_fault_8_n) else $error("fault 5 wrong");
    chk_fault_eight_low: assert property (margin_n && monitored_supply_8 ##1 monitored_supply_8
        |-> !channel_fault_8_n) else $error("fault 8 not low");
    chk_fault_eight_rise: assert property ($fell(monitored_supply_8) && $past(margin_n)
        |=> $rose(channel_fault_8_n)) else $error("fault 8 not released");
    chk_margin_high: assert property (!margin_n
        |=> channel_fault_5_n && channel_fault_8_n && reset_out_n) else $error("margin not forcing");
    chk_manual_reset_low: assert property (!manual_reset_input_n ##1 margin_n [*2]
        |=> !reset_out_n) else $error("manual reset missed");
    chk_supply_reset_low: assert property (monitored_supply_6 ##1 margin_n [*2]
        |=> !reset_out_n) else $error("supply reset missed");
    chk_manual_hold_on: assert property ($rose(manual_reset_input_n) ##0 margin_n [*8]
        |=> !reset_out_n) else $error("hold too short");
    chk_supply_hold_on: assert property ($fell(monitored_supply_5) ##0 margin_n [*4]
        |=> !reset_out_n) else $error("supply hold short");
    cover property ($fell(reset_out_n));
    cover property ($rose(reset_out_n));
    cover property (!margin_n && monitored_supply_5);
endmodule
bind svw_supervisor svw_supervisor_properties u_props (
    .clk_sys              (clk_sys),
    .arst_n               (arst_n),
    .monitored_supply_5   (monitored_supply_5),
    .monitored_supply_6   (monitored_supply_6),
    .monitored_supply_8   (monitored_supply_8),
    .manual_reset_input_n (manual_reset_input_n),
    .margin_n             (margin_n),
    .channel_fault_5_n    (channel_fault_5_n),
    .channel_fault_8_n    (channel_fault_8_n),
    .reset_out_n          (reset_out_n)
);
`default_nettype wire

// ### tb/svw_host_model.sv
// host model toggling the watchdog kick pin
`timescale 1ns/100ps
`default_nettype none
module svw_host_model #(parameter int PERIOD = 10) (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic undriven,
    output logic watchdog_kick_input,
    output logic watchdog_kick_floating
);
    int cnt = 0;
    logic last = 1'b0;
    logic kick = 1'b0;
    assign watchdog_kick_input    = kick;
    assign watchdog_kick_floating = undriven;
    // a released pin shows the inverse of its last driven level
    always @(posedge clk_sys) begin
        #1 cnt = (cnt + 1) % PERIOD;
        if (undriven) kick = !last;
        else begin
            if (run && cnt == 0) kick = !kick;
            last = kick;
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the supervisor block
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int HOLD = 20;
    localparam int TMO = 50;
    localparam int STUP = 200;
    logic clk_sys, arst_n, manual_reset_input_n, timeout_select_pin, ext_timeout_done, margin_n, run, undriven;
    logic [3:0] sup;
    wire monitored_supply_5 = sup[0], monitored_supply_6 = sup[1], monitored_supply_7 = sup[2];
    wire monitored_supply_8 = sup[3];
    wire channel_fault_5_n, channel_fault_6_n, channel_fault_7_n, channel_fault_8_n, reset_out_n, ext_timeout_run;
    wire watchdog_kick_input, watchdog_kick_floating;
    wire [4:0] outs = {reset_out_n, channel_fault_8_n, channel_fault_7_n, channel_fault_6_n, channel_fault_5_n};
    int fail_count = 0;
    int checked = 0;
    int n;
    svw_supervisor #(.STARTUP_CYC(STUP), .TIMEOUT_CYC(TMO), .RST_HOLD_CYC(HOLD)) dut (.*);
    svw_host_model #(.PERIOD(10)) host (.*);
    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic w(int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_rst(logic lvl, int lim);
        n = 0;
        while (reset_out_n !== lvl && n < lim) begin
            w(1);
            n++;
        end
    endtask
    task stop_test;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task t_power_up;
        wait_rst(1'b0, 10);
        chk("power-on assert", 1, n < 10);
        wait_rst(1'b1, 60);
        chk("power-on hold", 1, n >= HOLD - 1);
    endtask
    task t_ext_hold;
        timeout_select_pin = 0;
        manual_reset_input_n = 0;
        w(3);
        chk("ext run idle", 0, ext_timeout_run);
        manual_reset_input_n = 1;
        w(3);
        chk("ext run", 1, ext_timeout_run);
        w(HOLD + 10);
        chk("ext hold", 0, reset_out_n);
        ext_timeout_done = 1;
        w(3);
        chk("ext release", 1, reset_out_n);
        chk("ext run off", 0, ext_timeout_run);
        ext_timeout_done = 0;
        timeout_select_pin = 1;
    endtask
    task t_channels;
        for (int i = 0; i < 4; i++) begin
            sup = 4'h1 << i;
            w(3);
            chk("outputs", {1'b0, ~sup}, outs);
            sup = 4'h0;
            wait_rst(1'b1, 60);
            chk("hold", 1, n >= HOLD - 1 && n <= HOLD + 4);
        end
    endtask
    task t_margin;
        sup = 4'hf;
        margin_n = 0;
        w(3);
        chk("masked", 5'h1f, outs);
        margin_n = 1;
        w(3);
        chk("unmasked", 5'h00, outs);
        sup = 4'h0;
        manual_reset_input_n = 0;
        w(3);
        chk("manual", 0, reset_out_n);
        manual_reset_input_n = 1;
        wait_rst(1'b1, 60);
        chk("manual hold", 1, n >= HOLD - 1);
    endtask
    task t_watchdog;
        w(150);
        chk("kicked", 1, reset_out_n);
        run = 0;
        wait_rst(1'b0, 300);
        chk("timeout", 1, n >= TMO - 10 && n <= TMO + 4);
        wait_rst(1'b1, 60);
        wait_rst(1'b0, 400);
        chk("startup", 1, n >= STUP - 2 && n <= STUP + 4);
        run = 1;
        wait_rst(1'b1, 60);
        undriven = 1;
        w(STUP + 2 * TMO);
        chk("floating", 1, reset_out_n);
        undriven = 0;
    endtask
    initial begin
        {arst_n, sup, ext_timeout_done, undriven} = 0;
        {manual_reset_input_n, timeout_select_pin, margin_n, run} = 4'hf;
        w(4);
        arst_n = 1;
        t_power_up;
        t_channels;
        t_margin;
        t_ext_hold;
        t_watchdog;
        stop_test;
    end
    initial begin
        #100us;
        fail_count++;
        stop_test;
    end
endmodule
`default_nettype wire
